//--- src/rss_map.svh
// Register offsets, reset values, field positions and timing counts
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// ****************************************************************
// Register offsets (host port subaddresses)
// ****************************************************************
`define RSS_ADDR_BB 8'h19
`define RSS_ADDR_SLEW 8'h1A
`define RSS_ADDR_LDO 8'h1B

// ****************************************************************
// Reset values
// ****************************************************************
`define RSS_RST_BB 8'hA2
`define RSS_RST_SLEW 8'h06
`define RSS_RST_LDO 8'h3D

// ****************************************************************
// Field positions
// ****************************************************************
`define RSS_BIT_PSKIP 7
`define RSS_BIT_GO 7
`define RSS_BIT_AUTO 6
`define RSS_SLEW_IMMED 3'h7
`define RSS_SLEW_FASTEST 3'h6

// ****************************************************************
// Voltage decode of the buck-boost code, in millivolts
// ****************************************************************
`define RSS_MV_BASE 12'h0497
`define RSS_MV_FINE 12'h0019
`define RSS_MV_COARSE 12'h0032
`define RSS_CODE_KNEE 6'h0F

// ****************************************************************
// Timing
// ****************************************************************
`define RSS_CLK_PERIOD_NS 10
`define RSS_BLANK_MS 5
`define RSS_BLANK_CYC (`RSS_BLANK_MS * 1000000 / `RSS_CLK_PERIOD_NS)
`define RSS_STEP_MIN_NS 2500
`define RSS_STEP_MIN_CYC (`RSS_STEP_MIN_NS / `RSS_CLK_PERIOD_NS)

`endif

//--- src/rss_pkg.sv
// Types shared by the set-point and slew register block
package rss_pkg;

  // Decoded register access from the serial host port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rss_req_s;

  // Six-bit voltage code
  typedef logic [5:0] rss_code_t;

  // Pacing channel state
  typedef enum logic {
    RSS_ST_IDLE = 1'b0,
    RSS_ST_MOVE = 1'b1
  } rss_step_e;

endpackage

//--- src/rss_slew_step.sv
// One paced set-point channel: walks its code one step per period
`timescale 1ns/1ps
`default_nettype none

module rss_slew_step #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control
  input wire logic start_i,
  input wire logic immediate_i,
  input wire rss_pkg::rss_code_t target_i,
  input wire logic [CNT_W-1:0] period_i,
  // State
  output rss_pkg::rss_code_t code_o,
  output logic busy_o
);

  rss_pkg::rss_step_e st_q, st_d;
  rss_pkg::rss_code_t code_q, code_d, tgt_q, tgt_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  // Next state: one code step each time the period expires
  always_comb begin
    st_d = st_q;
    code_d = code_q;
    tgt_d = tgt_q;
    cnt_d = cnt_q;
    if (start_i) begin
      tgt_d = target_i;
      cnt_d = '0;
      if (immediate_i || target_i == code_q) begin
        code_d = target_i;
        st_d = rss_pkg::RSS_ST_IDLE;
      end else begin
        st_d = rss_pkg::RSS_ST_MOVE;
      end
    end else begin
      case (st_q)
        rss_pkg::RSS_ST_MOVE: begin
          // A switch to the immediate setting ends the move at once
          if (immediate_i) begin
            code_d = tgt_q;
            st_d = rss_pkg::RSS_ST_IDLE;
          end else if (cnt_q >= period_i - 1'b1) begin // Per step
            cnt_d = '0;
            code_d = (code_q < tgt_q) ? code_q + 6'h01 : code_q - 6'h01;
            if (code_d == tgt_q) begin
              st_d = rss_pkg::RSS_ST_IDLE;
            end
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        default: st_d = rss_pkg::RSS_ST_IDLE;
      endcase
    end
  end

  // Registers; the code starts at zero until the first transition
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_q <= rss_pkg::RSS_ST_IDLE;
      code_q <= 6'h00;
      tgt_q <= 6'h00;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      code_q <= code_d;
      tgt_q <= tgt_d;
      cnt_q <= cnt_d;
    end
  end

  assign code_o = code_q;
  assign busy_o = (st_q == rss_pkg::RSS_ST_MOVE);

  // Code holds between step boundaries
  property p_hold_between_steps;
    @(posedge core_clk_i) disable iff (reset_i)
    (busy_o && !start_i && !immediate_i && cnt_q < period_i - 1'b1)
      |=> $stable(code_o);
  endproperty
  a_hold_between_steps: assert property (p_hold_between_steps)
    else $error("code moved before its step period expired");

endmodule // rss_slew_step

`default_nettype wire

//--- src/rss_regs.sv
// Set-point, pulse-skip and slew control registers of the regulators
`include "rss_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rss_regs #(
  parameter int BLANK_CYC = `RSS_BLANK_CYC,
  parameter int STEP_BASE_CYC = `RSS_STEP_MIN_CYC,
  parameter int CNT_W = 16,
  parameter int BLANK_W = 20
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Decoded host port access and write-protection state
  input wire rss_pkg::rss_req_s req_i,
  input wire logic unlock_i,
  output logic [7:0] rdata_o,
  // Resistor-selected power-up default
  input wire logic resistor_config_select_valid_i,
  input wire rss_pkg::rss_code_t resistor_config_select_code_i,
  // Step-down converter set-point writes and stored targets
  input wire logic sd1_wr_i,
  input wire logic sd2_wr_i,
  input wire rss_pkg::rss_code_t sd1_target_i,
  input wire rss_pkg::rss_code_t sd2_target_i,
  // Regulator controls
  output rss_pkg::rss_code_t sd1_code_o,
  output rss_pkg::rss_code_t sd2_code_o,
  output logic slewing_o,
  output rss_pkg::rss_code_t bb_code_o,
  output logic bb_pulse_skip_o,
  output logic [11:0] bb_mv_o,
  output rss_pkg::rss_code_t ldo_code_o,
  output logic ov_uv_blank_o
);
  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (STEP_BASE_CYC < 1
      || (STEP_BASE_CYC << 6) >= (1 << CNT_W)) begin : g_chk_step
    $error("STEP_BASE_CYC does not fit the pacing counter");
  end
  if (BLANK_CYC < 1 || BLANK_CYC >= (1 << BLANK_W)) begin : g_chk_blank
    $error("BLANK_CYC does not fit the blanking counter");
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic wr_hit(rss_pkg::rss_req_s r, logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction
  // Step period doubles for each code below the fastest one
  function automatic logic [CNT_W-1:0] step_period(logic [2:0] s);
    return CNT_W'(STEP_BASE_CYC) << (`RSS_SLEW_FASTEST - s);
  endfunction
  // 25 mV steps up to the knee, 50 mV steps above it
  function automatic logic [11:0] bb_decode(rss_pkg::rss_code_t c);
    if (c <= `RSS_CODE_KNEE) begin
      return `RSS_MV_BASE + 12'(c) * `RSS_MV_FINE;
    end
    return `RSS_MV_BASE + 12'(`RSS_CODE_KNEE) * `RSS_MV_FINE
      + (12'(c) - 12'h00F) * `RSS_MV_COARSE;
  endfunction
  // ****************************************************************
  // Register state
  // ****************************************************************
  logic pskip_q, pskip_d, go_q, go_d, auto_q, auto_d;
  logic strap_done_q, strap_done_d, start_q, start_d;
  logic [2:0] slew_q, slew_d, slew_eff;
  rss_pkg::rss_code_t bb_q, bb_d, ldo_q, ldo_d;
  logic [7:0] rdata_q, rdata_d;
  logic [11:0] mv_q, mv_d;
  logic [BLANK_W-1:0] blank_q, blank_d;
  logic wr_bb, wr_ldo, wr_slew, start, busy_any;
  logic [1:0] ch_busy;
  rss_pkg::rss_code_t ch_tgt [2];
  rss_pkg::rss_code_t ch_code [2];
  assign wr_bb = wr_hit(req_i, `RSS_ADDR_BB);
  assign wr_ldo = wr_hit(req_i, `RSS_ADDR_LDO);
  assign wr_slew = wr_hit(req_i, `RSS_ADDR_SLEW);
  assign busy_any = |ch_busy;
  // Paced transition: go bit written, or auto mode on a set-point write
  assign start = (wr_slew && req_i.wdata[`RSS_BIT_GO])
    || (auto_q && (sd1_wr_i || sd2_wr_i));
  // A slew write that also starts a move paces it at the new rate
  assign slew_eff = wr_slew ? req_i.wdata[2:0] : slew_q;
  // Next register values
  always_comb begin
    pskip_d = pskip_q;
    bb_d = bb_q;
    ldo_d = ldo_q;
    auto_d = auto_q;
    slew_d = slew_q;
    go_d = go_q;
    strap_done_d = 1'b1;
    start_d = start;
    // Strap is caught on the first edge after release
    if (!strap_done_q && resistor_config_select_valid_i) begin
      bb_d = resistor_config_select_code_i;
    end
    if (wr_bb && unlock_i) begin
      pskip_d = req_i.wdata[`RSS_BIT_PSKIP];
      bb_d = req_i.wdata[5:0]; // Bit 6 dropped
    end
    if (wr_ldo && unlock_i) begin
      ldo_d = req_i.wdata[5:0]; // Bits 7-6 dropped
    end
    if (wr_slew) begin
      auto_d = req_i.wdata[`RSS_BIT_AUTO];
      slew_d = req_i.wdata[2:0]; // Bits 5-3 dropped
    end
    // Self-clear once both channels settle; a new go write wins
    if (go_q && !start_q && !busy_any) begin
      go_d = 1'b0;
    end
    if (wr_slew && req_i.wdata[`RSS_BIT_GO]) begin
      go_d = 1'b1;
    end
  end
  // Blanking restarts on every guarded write, even a locked one
  always_comb begin
    if (wr_bb || wr_ldo) begin
      blank_d = BLANK_W'(BLANK_CYC);
    end else if (blank_q != '0) begin
      blank_d = blank_q - 1'b1;
    end else begin
      blank_d = '0;
    end
  end
  // Read data and voltage decode, registered
  always_comb begin
    mv_d = bb_decode(bb_q);
    rdata_d = rdata_q;
    if (req_i.rd) begin
      case (req_i.addr)
        `RSS_ADDR_BB: rdata_d = {pskip_q, 1'b0, bb_q};
        `RSS_ADDR_SLEW: rdata_d = {go_q, auto_q, 3'h0, slew_q};
        `RSS_ADDR_LDO: rdata_d = {2'h0, ldo_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end
  // Register update
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pskip_q <= 1'(`RSS_RST_BB >> `RSS_BIT_PSKIP);
      bb_q <= 6'(`RSS_RST_BB & 8'h3F);
      ldo_q <= 6'(`RSS_RST_LDO & 8'h3F);
      go_q <= 1'(`RSS_RST_SLEW >> `RSS_BIT_GO);
      auto_q <= 1'b0;
      slew_q <= 3'(`RSS_RST_SLEW & 8'h07);
      strap_done_q <= 1'b0;
      start_q <= 1'b0;
      blank_q <= '0;
      rdata_q <= 8'h00;
      mv_q <= 12'h0000;
    end else begin
      pskip_q <= pskip_d;
      bb_q <= bb_d;
      ldo_q <= ldo_d;
      go_q <= go_d;
      auto_q <= auto_d;
      slew_q <= slew_d;
      strap_done_q <= strap_done_d;
      start_q <= start_d;
      blank_q <= blank_d;
      rdata_q <= rdata_d;
      mv_q <= mv_d;
    end
  end
  // ****************************************************************
  // Paced channels: only the two step-down converters
  // ****************************************************************
  assign ch_tgt[0] = sd1_target_i;
  assign ch_tgt[1] = sd2_target_i;
  for (genvar i = 0; i < 2; i++) begin : g_ch
    rss_slew_step #(.CNT_W(CNT_W)) u_step (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .start_i(start),
      .immediate_i(slew_eff == `RSS_SLEW_IMMED),
      .target_i(ch_tgt[i]),
      .period_i(step_period(slew_eff)),
      .code_o(ch_code[i]),
      .busy_o(ch_busy[i])
    );
  end
  // Outputs; buck-boost and linear codes apply unpaced
  assign sd1_code_o = ch_code[0];
  assign sd2_code_o = ch_code[1];
  assign slewing_o = busy_any;
  assign bb_code_o = bb_q;
  assign bb_pulse_skip_o = pskip_q;
  assign bb_mv_o = mv_q;
  assign ldo_code_o = ldo_q;
  assign ov_uv_blank_o = (blank_q != '0);
  assign rdata_o = rdata_q;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_bb_reset;
    @(posedge core_clk_i) reset_i |=> (bb_q == 6'h22) && pskip_q;
  endproperty
  a_bb_reset: assert property (p_bb_reset)
    else $error("buck-boost register not at reset value");
  property p_locked_write;
    @(posedge core_clk_i) disable iff (reset_i)
    (wr_bb && !unlock_i && strap_done_q) |=> $stable({pskip_q, bb_q});
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("locked write changed buck-boost register");
  property p_blank_window;
    @(posedge core_clk_i) disable iff (reset_i)
    (wr_bb || wr_ldo) |=> ov_uv_blank_o && (blank_q == BLANK_W'(BLANK_CYC));
  endproperty
  a_blank_window: assert property (p_blank_window)
    else $error("guarded write did not start blanking");
  property p_blank_end;
    @(posedge core_clk_i) disable iff (reset_i)
    (blank_q == 1 && !wr_bb && !wr_ldo) |=> !ov_uv_blank_o;
  endproperty
  a_blank_end: assert property (p_blank_end)
    else $error("blanking outlasted its window");
  property p_strap_load;
    @(posedge core_clk_i) disable iff (reset_i)
    (!strap_done_q && resistor_config_select_valid_i && !wr_bb) |=> bb_q == $past(resistor_config_select_code_i);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("strap default not loaded");
  property p_bb_top_code;
    @(posedge core_clk_i) disable iff (reset_i)
    (bb_q == 6'h34) |=> bb_mv_o == 12'h0D48;
  endproperty
  a_bb_top_code: assert property (p_bb_top_code)
    else $error("top buck-boost code not decoded as 3.400 V");
  property p_slew_reset;
    @(posedge core_clk_i) reset_i |=> (slew_q == 3'h6) && !go_q && !auto_q;
  endproperty
  a_slew_reset: assert property (p_slew_reset)
    else $error("slew register not at reset value");
  property p_go_clears;
    @(posedge core_clk_i) disable iff (reset_i)
    (go_q && !start_q && !busy_any && !start) |=> !go_q;
  endproperty
  a_go_clears: assert property (p_go_clears)
    else $error("go bit stayed set after transition");
  property p_auto_start;
    @(posedge core_clk_i) disable iff (reset_i)
    (auto_q && sd1_wr_i && sd1_target_i != sd1_code_o
      && slew_eff != `RSS_SLEW_IMMED) |=> ch_busy[0];
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("auto mode did not start a transition");
  property p_immediate;
    @(posedge core_clk_i) disable iff (reset_i)
    (start && slew_eff == `RSS_SLEW_IMMED)
      |=> sd1_code_o == $past(sd1_target_i) && !slewing_o;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate slew did not apply target at once");
  property p_reserved_zero;
    @(posedge core_clk_i) disable iff (reset_i)
    (req_i.rd && req_i.addr == `RSS_ADDR_SLEW) |=> rdata_o[5:3] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved slew bits read nonzero");
  c_go_done: cover property (@(posedge core_clk_i) go_q ##1 !go_q);
  c_auto_run: cover property (@(posedge core_clk_i) disable iff (reset_i)
    auto_q && sd2_wr_i ##1 slewing_o);
  c_blank_over: cover property (@(posedge core_clk_i) disable iff (reset_i)
    ov_uv_blank_o ##1 !ov_uv_blank_o);

endmodule // rss_regs

`default_nettype wire

//--- testbench/rss_host_model.sv
// Host model: issues decoded register accesses into the block
`timescale 1ns/1ps
`default_nettype none

module rss_host_model (
  // Clock
  input wire logic core_clk_i,
  // Register port
  output rss_pkg::rss_req_s req_o,
  output logic unlock_o,
  input wire logic [7:0] rdata_i
);
  // ****
  // Bus idle state
  // ****
  initial begin
    req_o = '0;
    unlock_o = 1'b0;
  end

  // One write: launched on a falling edge, taken at the next rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                        input logic ul);
    @(negedge core_clk_i);
    // Reserved buck-boost codes are never sent
    if (a == 8'h19 && d[5:0] > 6'h34) d[5:0] = 6'h34;
    req_o.wr = 1'b1;
    req_o.addr = a;
    req_o.wdata = d;
    unlock_o = ul;
    @(negedge core_clk_i);
    // Released lines flip so a stale value never looks valid
    req_o.wr = 1'b0;
    req_o.addr = ~req_o.addr;
    req_o.wdata = ~req_o.wdata;
    unlock_o = 1'b0;
  endtask

  // One read: data is taken one cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    req_o.rd = 1'b1;
    req_o.addr = a;
    @(negedge core_clk_i);
    req_o.rd = 1'b0;
    req_o.addr = ~req_o.addr;
    d = rdata_i;
  endtask
endmodule // rss_host_model

`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking testbench of the set-point and slew registers
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // Short counts keep the run small
  localparam int BLANK = 50;
  localparam int BASE = 2;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  rss_pkg::rss_req_s req;
  logic unlock;
  logic [7:0] rdata;
  logic resistor_config_select_valid = 1'b0;
  rss_pkg::rss_code_t resistor_config_select_code = 6'h10;
  logic sd1_wr = 1'b0;
  logic sd2_wr = 1'b0;
  rss_pkg::rss_code_t sd1_t = 6'h00;
  rss_pkg::rss_code_t sd2_t = 6'h00;
  rss_pkg::rss_code_t sd1_c, sd2_c, bb_code, ldo_code;
  logic slewing, pskip, blank;
  logic [11:0] mv;
  int err_count = 0;
  int comparisons = 0;
  logic [7:0] rv;
  int n, p;
  logic [5:0] cd [4] = '{6'h00, 6'h0F, 6'h10, 6'h34};
  logic [11:0] mvt [4] = '{12'h0497, 12'h060E, 12'h0640, 12'h0D48};

  // 100 MHz clock
  always #5 core_clk_i = ~core_clk_i;

  // ****
  // Design and host model
  // ****
  rss_host_model host (.core_clk_i(core_clk_i), .req_o(req),
    .unlock_o(unlock), .rdata_i(rdata));

  rss_regs #(.BLANK_CYC(BLANK), .STEP_BASE_CYC(BASE)) dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(req),
    .unlock_i(unlock), .rdata_o(rdata), .resistor_config_select_valid_i(resistor_config_select_valid),
    .resistor_config_select_code_i(resistor_config_select_code), .sd1_wr_i(sd1_wr), .sd2_wr_i(sd2_wr),
    .sd1_target_i(sd1_t), .sd2_target_i(sd2_t), .sd1_code_o(sd1_c),
    .sd2_code_o(sd2_c), .slewing_o(slewing), .bb_code_o(bb_code),
    .bb_pulse_skip_o(pskip), .bb_mv_o(mv), .ldo_code_o(ldo_code),
    .ov_uv_blank_o(blank));

  // ****
  // Shared tasks
  // ****
  task automatic test_done();
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] got,
                     input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, rv);
    chk($sformatf("reg %h", a), 12'(rv), 12'(exp));
  endtask

  task automatic rst();
    reset_i = 1'b1;
    repeat (10) @(negedge core_clk_i);
    reset_i = 1'b0;
  endtask

  // Bounded wait for the paced channels to settle
  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (slewing === 1'b1) begin
      @(negedge core_clk_i);
      cnt++;
      if (cnt > 2000) begin
        chk("slew hang", 12'h000, 12'h001);
        test_done();
      end
    end
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    rst();
    rdc(8'h19, 8'hA2);
    rdc(8'h1A, 8'h06);
    rdc(8'h1B, 8'h3D);
    rdc(8'h1C, 8'h00);
    chk("pskip", 12'(pskip), 12'h001);
    chk("mv", mv, 12'h09C4);
    // Locked write keeps the value but still blanks the monitors
    host.wr_reg(8'h19, 8'h05, 1'b0);
    chk("blank", 12'(blank), 12'h001);
    rdc(8'h19, 8'hA2);
    host.wr_reg(8'h19, 8'h45, 1'b1);
    chk("bb code", 12'(bb_code), 12'h005);
    chk("pskip", 12'(pskip), 12'h000);
    @(negedge core_clk_i);
    chk("mv", mv, 12'h0514);
    rdc(8'h19, 8'h05);
    // Code table edges: base, knee, first coarse step, top
    for (int i = 0; i < 4; i++) begin
      host.wr_reg(8'h19, {2'b10, cd[i]}, 1'b1);
      @(negedge core_clk_i);
      chk("mv", mv, mvt[i]);
    end
    host.wr_reg(8'h1B, 8'h05, 1'b0);
    rdc(8'h1B, 8'h3D);
    host.wr_reg(8'h1B, 8'hC7, 1'b1);
    rdc(8'h1B, 8'h07);
    chk("ldo code", 12'(ldo_code), 12'h007);
    n = 0;
    while (blank === 1'b1 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("blank len", 12'(n >= BLANK - 4 && n <= BLANK + 1), 12'h001);
    if (n >= 2000) test_done();
    // Go bit moves both channels, then clears itself
    sd1_t = 6'h02;
    sd2_t = 6'h01;
    host.wr_reg(8'h1A, 8'h86, 1'b1);
    rdc(8'h1A, 8'h86);
    wait_idle(n);
    @(negedge core_clk_i);
    chk("sd1", 12'(sd1_c), 12'h002);
    chk("sd2", 12'(sd2_c), 12'h001);
    rdc(8'h1A, 8'h06);
    // Every step time, two code steps each
    for (int k = 0; k < 7; k++) begin
      sd1_t = k[0] ? 6'h02 : 6'h04; // Target alternates between 4 and 2
      host.wr_reg(8'h1A, 8'h80 | 8'(k), 1'b1);
      wait_idle(n);
      p = 2 * (BASE << (6 - k));
      chk($sformatf("slew %0d time", k), 12'(n >= p - 2 && n <= p + 1),
          12'h001);
      chk("sd1", 12'(sd1_c), 12'(sd1_t));
      chk("sd2", 12'(sd2_c), 12'h001);
    end
    // Automatic mode: a set-point write starts the move, go stays clear
    host.wr_reg(8'h1A, 8'h46, 1'b1);
    sd1_t = 6'h05;
    @(negedge core_clk_i);
    sd1_wr = 1'b1;
    @(negedge core_clk_i);
    sd1_wr = 1'b0;
    wait_idle(n);
    @(negedge core_clk_i);
    chk("sd1 auto", 12'(sd1_c), 12'h005);
    // The second set-point write starts a move just the same
    sd2_t = 6'h03;
    sd2_wr = 1'b1;
    @(negedge core_clk_i);
    sd2_wr = 1'b0;
    wait_idle(n);
    chk("sd2 auto", 12'(sd2_c), 12'h003);
    rdc(8'h1A, 8'h46);
    // Immediate setting applies the target without pacing
    sd1_t = 6'h01;
    host.wr_reg(8'h1A, 8'h87, 1'b1);
    @(negedge core_clk_i);
    chk("sd1 immed", 12'(sd1_c), 12'h001);
    chk("slewing", 12'(slewing), 12'h000);
    host.wr_reg(8'h1A, 8'h3E, 1'b1);
    rdc(8'h1A, 8'h06);
    // Second reset with a strapped default
    resistor_config_select_valid = 1'b1;
    rst();
    rdc(8'h19, 8'h90);
    test_done();
  end
endmodule // tb_top

`default_nettype wire
